// [core/dac_ctrl_pkg.sv]
// Purpose: Shared constants and state carriers for the dual-mode control port
// Assumes: Eight 8-bit setting registers behind a 3-bit pointer index
// Notes: State types follow the one-struct-per-module style
package dac_ctrl_pkg;

  // Setting bank geometry
  localparam int REG_COUNT = 8;
  localparam int IDX_W = 3;
  localparam int BYTE_W = 8;

  // Chip addresses: fixed in four-wire mode, upper bits only in two-wire mode
  localparam logic [6:0] FOUR_WIRE_ADDR = 7'h10;
  localparam logic [4:0] TWO_WIRE_ADDR_HI = 5'h04;

  // Pointer byte layout and reset values
  localparam int PTR_ADVANCE_BIT = 7;
  localparam int PTR_IDX_LSB = 0;
  localparam logic [IDX_W-1:0] PTR_IDX_RESET = 3'h1;
  localparam logic PTR_ADVANCE_RESET = 1'b0;
  localparam logic [BYTE_W-1:0] SETTING_RESET = 8'h00;

  // Bit counter figures
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_STEP = 3'h1;

  // Synchronised pin group
  localparam int PIN_COUNT = 4;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_WDATA,
    ST_RDATA,
    ST_ACK,
    ST_MACK,
    ST_IGNORE
  } port_state_t;

  // Synchronised pin levels
  typedef struct packed {
    logic clk;
    logic sda;
    logic sel;
    logic din;
  } pins_t;

  // Whole state of the control port
  typedef struct packed {
    logic fourWire;
    port_state_t state;
    port_state_t afterAck;
    logic [2:0] bitCnt;
    logic [BYTE_W-1:0] shiftIn;
    logic [BYTE_W-1:0] txByte;
    logic [IDX_W-1:0] ptrIdx;
    logic ptrAdvance;
    logic ackPhase;
    logic clkPrev;
    logic sdaPrev;
    logic selPrev;
    logic dout;
    logic doe;
    logic wrEn;
    logic [IDX_W-1:0] wrIdx;
    logic [BYTE_W-1:0] wrData;
  } port_reg_t;

  // Whole state of the setting bank
  typedef struct packed {
    logic [REG_COUNT-1:0][BYTE_W-1:0] regs;
  } bank_reg_t;

endpackage : dac_ctrl_pkg

// [core/dac_dual_mode_control_port.sv]
// Purpose: Slave control port working in four-wire select-framed or two-wire mode
// Assumes: Host pins are sampled by ref_clk; host clock far slower than ref_clk
// Notes: Settings registers live in setting_bank; pins pass two flip-flops first
`timescale 1ns/10ps
module dac_dual_mode_control_port
  import dac_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic controlBitClock,
  input wire logic addressStrapLow,
  input wire logic controlSerialIn,
  input wire logic dataLineIn,
  output logic dataLineOut,
  output logic dataLineOe,
  output logic fourWireMode,
  output logic [REG_COUNT*BYTE_W-1:0] settings
);

  port_reg_t port_reg;
  port_reg_t port_next;
  pins_t pinsSync;
  logic [BYTE_W-1:0] rdData;

  // Every host pin is asynchronous to ref_clk, so all four are synchronised
  pin_sync #(
    .WIDTH(PIN_COUNT)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pinsAsync({controlBitClock, dataLineIn, addressStrapLow, controlSerialIn}),
    .pinsSync(pinsSync)
  );

  // Settings written by the host; read port follows the pointer
  setting_bank u_setting_bank (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .wrEn(port_reg.wrEn),
    .wrIdx(port_reg.wrIdx),
    .wrData(port_reg.wrData),
    .rdIdx(port_reg.ptrIdx),
    .rdData(rdData),
    .settings(settings)
  );

  // Whole port behaviour; host clock edges are found by comparing samples
  always_comb begin
    logic clkRise;
    logic clkFall;
    logic startCond;
    logic stopCond;
    logic bitIn;
    logic byteEnd;
    logic [BYTE_W-1:0] rxByte;
    port_next = port_reg;
    clkRise = pinsSync.clk & ~port_reg.clkPrev;
    clkFall = ~pinsSync.clk & port_reg.clkPrev;
    startCond = pinsSync.clk & port_reg.clkPrev & port_reg.sdaPrev & ~pinsSync.sda;
    stopCond = pinsSync.clk & port_reg.clkPrev & ~port_reg.sdaPrev & pinsSync.sda;
    bitIn = port_reg.fourWire ? pinsSync.din : pinsSync.sda;
    rxByte = {port_reg.shiftIn[BYTE_W-2:0], bitIn};
    byteEnd = clkRise && (port_reg.bitCnt == BIT_LAST);
    port_next.wrEn = 1'b0;
    port_next.clkPrev = pinsSync.clk;
    port_next.sdaPrev = pinsSync.sda;
    port_next.selPrev = pinsSync.sel;

    // Sticky mode switch; only reset clears it
    if (port_reg.selPrev && !pinsSync.sel) begin
      port_next.fourWire = 1'b1;
    end

    if (port_reg.fourWire) begin
      // Four-wire: select high ends any frame and frees the output
      port_next.dout = port_reg.dout;
      if (pinsSync.sel) begin
        port_next.state = ST_IDLE;
        port_next.bitCnt = BIT_FIRST;
        port_next.doe = 1'b0;
      end else begin
        if (port_reg.state == ST_IDLE) begin
          port_next.state = ST_ADDR;
          port_next.bitCnt = BIT_FIRST; // Mode switch may land mid-byte of a two-wire frame
          port_next.doe = 1'b1;
        end
        if (clkRise && port_reg.state != ST_IDLE) begin
          port_next.shiftIn = rxByte;
          port_next.bitCnt = port_reg.bitCnt + BIT_STEP;
        end
        if (byteEnd) begin
          case (port_reg.state)
            ST_ADDR: begin
              if (rxByte[BYTE_W-1:1] == FOUR_WIRE_ADDR) begin
                if (rxByte[0]) begin
                  port_next.state = ST_RDATA;
                  port_next.txByte = rdData;
                  port_next.dout = rdData[BYTE_W-1];
                end else begin
                  port_next.state = ST_PTR;
                end
              end else begin
                port_next.state = ST_IGNORE;
              end
            end
            ST_PTR: begin
              port_next.ptrIdx = rxByte[PTR_IDX_LSB +: IDX_W];
              port_next.ptrAdvance = rxByte[PTR_ADVANCE_BIT];
              port_next.state = ST_WDATA;
            end
            ST_WDATA: begin
              port_next.wrEn = 1'b1;
              port_next.wrIdx = port_reg.ptrIdx;
              port_next.wrData = rxByte;
              if (port_reg.ptrAdvance) begin
                port_next.ptrIdx = port_reg.ptrIdx + 3'h1;
              end
            end
            ST_RDATA: begin
              if (port_reg.ptrAdvance) begin
                port_next.ptrIdx = port_reg.ptrIdx + 3'h1;
              end
            end
            default: begin
            end
          endcase
        end
        // Read data changes on falling edges so it is stable at the host's rise
        if (clkFall && port_reg.state == ST_RDATA) begin
          if (port_reg.bitCnt == BIT_FIRST) begin
            port_next.txByte = rdData;
            port_next.dout = rdData[BYTE_W-1];
          end else begin
            port_next.txByte = {port_reg.txByte[BYTE_W-2:0], 1'b0};
            port_next.dout = port_reg.txByte[BYTE_W-2];
          end
        end
      end
    end else begin
      // Two-wire: open drain, data line only ever pulled low; no select used
      port_next.dout = 1'b0;
      if (startCond) begin
        port_next.state = ST_ADDR;
        port_next.bitCnt = BIT_FIRST;
        port_next.doe = 1'b0;
        port_next.ackPhase = 1'b0;
      end else if (stopCond) begin
        port_next.state = ST_IDLE;
        port_next.doe = 1'b0;
      end else begin
        case (port_reg.state)
          ST_ADDR, ST_PTR, ST_WDATA: begin
            if (clkRise) begin
              port_next.shiftIn = rxByte;
              port_next.bitCnt = port_reg.bitCnt + BIT_STEP;
            end
            if (byteEnd) begin
              port_next.state = ST_ACK;
              port_next.ackPhase = 1'b0;
              if (port_reg.state == ST_ADDR) begin
                // Low address bits come from the static strap levels
                if (rxByte[BYTE_W-1:1] == {TWO_WIRE_ADDR_HI, pinsSync.din, pinsSync.sel}) begin
                  port_next.afterAck = rxByte[0] ? ST_RDATA : ST_PTR;
                end else begin
                  port_next.state = ST_IGNORE;
                end
              end else if (port_reg.state == ST_PTR) begin
                port_next.ptrIdx = rxByte[PTR_IDX_LSB +: IDX_W];
                port_next.ptrAdvance = rxByte[PTR_ADVANCE_BIT];
                port_next.afterAck = ST_WDATA;
              end else begin
                port_next.wrEn = 1'b1;
                port_next.wrIdx = port_reg.ptrIdx;
                port_next.wrData = rxByte;
                port_next.afterAck = ST_WDATA;
                if (port_reg.ptrAdvance) begin
                  port_next.ptrIdx = port_reg.ptrIdx + 3'h1;
                end
              end
            end
          end
          ST_ACK: begin
            // First fall pulls the line low, second fall releases or starts data
            if (clkFall) begin
              if (!port_reg.ackPhase) begin
                port_next.ackPhase = 1'b1;
                port_next.doe = 1'b1;
              end else begin
                port_next.ackPhase = 1'b0;
                port_next.state = port_reg.afterAck;
                port_next.bitCnt = BIT_FIRST;
                if (port_reg.afterAck == ST_RDATA) begin
                  port_next.txByte = rdData;
                  port_next.doe = ~rdData[BYTE_W-1];
                end else begin
                  port_next.doe = 1'b0;
                end
              end
            end
          end
          ST_RDATA: begin
            if (clkRise) begin
              port_next.bitCnt = port_reg.bitCnt + BIT_STEP;
              if (port_reg.bitCnt == BIT_LAST) begin
                port_next.state = ST_MACK;
                port_next.ackPhase = 1'b0;
                if (port_reg.ptrAdvance) begin
                  port_next.ptrIdx = port_reg.ptrIdx + 3'h1;
                end
              end
            end
            if (clkFall && port_reg.bitCnt != BIT_FIRST) begin
              port_next.txByte = {port_reg.txByte[BYTE_W-2:0], 1'b0};
              port_next.doe = ~port_reg.txByte[BYTE_W-2];
            end
          end
          ST_MACK: begin
            // Host acknowledge: low keeps reading, high ends the read
            if (clkFall) begin
              if (!port_reg.ackPhase) begin
                port_next.doe = 1'b0;
              end else begin
                port_next.ackPhase = 1'b0;
                port_next.state = ST_RDATA;
                port_next.bitCnt = BIT_FIRST;
                port_next.txByte = rdData;
                port_next.doe = ~rdData[BYTE_W-1];
              end
            end
            if (clkRise) begin
              if (pinsSync.sda) begin
                port_next.state = ST_IGNORE;
              end else begin
                port_next.ackPhase = 1'b1;
              end
            end
          end
          default: begin
            port_next.doe = 1'b0;
          end
        endcase
      end
    end
  end

  // Register the whole state; pointer index resets to its documented default
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      port_reg <= '0;
      port_reg.state <= ST_IDLE;
      port_reg.afterAck <= ST_IDLE;
      port_reg.ptrIdx <= PTR_IDX_RESET;
      port_reg.ptrAdvance <= PTR_ADVANCE_RESET;
    end else begin
      port_reg <= port_next;
    end
  end

  assign dataLineOut = port_reg.dout;
  assign dataLineOe = port_reg.doe;
  assign fourWireMode = port_reg.fourWire;

endmodule : dac_dual_mode_control_port

// [core/pin_sync.sv]
// Purpose: Two-stage synchroniser for a group of asynchronous pins
// Assumes: Pins are slow against ref_clk
// Notes: Only the second stage is visible outside
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] pinsAsync,
  output logic [WIDTH-1:0] pinsSync
);

  typedef struct packed {
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage1;
  } sync_reg_t;

  sync_reg_t sync_reg;
  sync_reg_t sync_next;

  // Refuse an empty group
  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync needs at least one pin");
  end

  // First stage feeds only the second stage, to keep metastability contained
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign sync_next.stage1[i] = pinsAsync[i];
    assign sync_next.stage2[i] = sync_reg.stage1[i];
  end

  // Both stages clear to low under reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign pinsSync = sync_reg.stage2;

endmodule : pin_sync

// [core/setting_bank.sv]
// Purpose: Register bank holding the settings loaded through the control port
// Assumes: One write per cycle, single combinational read port
// Notes: Contents leave straight from flip-flops
`timescale 1ns/10ps
module setting_bank
  import dac_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wrEn,
  input wire logic [IDX_W-1:0] wrIdx,
  input wire logic [BYTE_W-1:0] wrData,
  input wire logic [IDX_W-1:0] rdIdx,
  output logic [BYTE_W-1:0] rdData,
  output logic [REG_COUNT*BYTE_W-1:0] settings
);

  bank_reg_t bank_reg;
  bank_reg_t bank_next;

  // Single write port
  always_comb begin
    bank_next = bank_reg;
    if (wrEn) begin
      bank_next.regs[wrIdx] = wrData;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bank_reg <= {REG_COUNT{SETTING_RESET}};
    end else begin
      bank_reg <= bank_next;
    end
  end

  assign rdData = bank_reg.regs[rdIdx];
  assign settings = bank_reg.regs;

endmodule : setting_bank

// [sim/dac_port_assertions.sv]
// Purpose: Concurrent checks on the control port pins
// Assumes: Host clock far slower than ref_clk
// Notes: Bound to the port module after endmodule
`timescale 1ns/10ps
module dac_port_assertions
  import dac_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic controlBitClock,
  input wire logic addressStrapLow,
  input wire logic controlSerialIn,
  input wire logic dataLineIn,
  input wire logic dataLineOut,
  input wire logic dataLineOe,
  input wire logic fourWireMode,
  input wire logic [REG_COUNT*BYTE_W-1:0] settings
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic [3:0] clkQuiet;
  logic [3:0] selFallAge;

  // Saturating ages of the last host clock edge and select fall
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      clkQuiet <= 4'hF;
      selFallAge <= 4'hF;
    end else begin
      clkQuiet <= $changed(controlBitClock) ? 4'h0 : clkQuiet + {3'h0, clkQuiet != 4'hF};
      selFallAge <= $fell(addressStrapLow) ? 4'h0 : selFallAge + {3'h0, selFallAge != 4'hF};
    end
  end

  // Select held for longer than the synchroniser delay
  sequence selHeldLow;
    (fourWireMode && !addressStrapLow) [*6];
  endsequence
  sequence selHeldHigh;
    (fourWireMode && addressStrapLow) [*6];
  endsequence

  a_mode_entry: assert property ($fell(addressStrapLow) |-> ##[2:6] fourWireMode)
    else $error("mode not entered");
  a_mode_cause: assert property ($rose(fourWireMode) |-> selFallAge < 4'h7)
    else $error("mode entered without select fall");
  a_mode_sticky: assert property (fourWireMode |=> fourWireMode)
    else $error("mode left");
  a_sel_drive: assert property (selHeldLow |-> dataLineOe)
    else $error("output not driven while selected");
  a_sel_release: assert property (selHeldHigh |-> !dataLineOe)
    else $error("output driven while deselected");
  a_open_drain: assert property (!fourWireMode && dataLineOe |-> !dataLineOut)
    else $error("data line driven high");
  a_idle_settings: assert property (!$stable(settings) |-> clkQuiet < 4'h8)
    else $error("settings changed with idle clock");
  // Two-wire drive only moves while the host clock is low
  a_scl_high: assert property (!fourWireMode && controlBitClock && $past(controlBitClock, 2)
    |-> $stable(dataLineOe))
    else $error("data line moved during clock high");
endmodule : dac_port_assertions

bind dac_dual_mode_control_port dac_port_assertions chk (.ref_clk(ref_clk), .resetn(resetn),
  .controlBitClock(controlBitClock), .addressStrapLow(addressStrapLow),
  .controlSerialIn(controlSerialIn), .dataLineIn(dataLineIn), .dataLineOut(dataLineOut),
  .dataLineOe(dataLineOe), .fourWireMode(fourWireMode), .settings(settings));

// [sim/host_model.sv]
// Purpose: Host controller model driving the control port pins
// Assumes: Pins change 1 ns after a ref_clk rise
// Notes: Host clock period is 8 ref_clk cycles
`timescale 1ns/10ps
module host_model (
  input wire logic ref_clk,
  input wire logic sdaWire,
  output logic control_bit_clock,
  output logic selStrap,
  output logic dinStrap,
  output logic sdaDrv
);
  // Spare mode input is grounded on the board and is not a pin of this block
  // Two-wire idle: straps tied high, clock and data released
  initial begin
    control_bit_clock = 1'b1;
    selStrap = 1'b1;
    dinStrap = 1'b1;
    sdaDrv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  // Data moves only while the clock is low
  task automatic bit2(input logic b, output logic r);
    sdaDrv = b;
    tick(2);
    control_bit_clock = 1'b1;
    tick(2);
    r = sdaWire;
    tick(2);
    control_bit_clock = 1'b0;
    tick(2);
  endtask : bit2

  task automatic byte2(input logic [7:0] tx, output logic [7:0] rx);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit2(tx[i], r);
      rx = {rx[6:0], r};
    end
  endtask : byte2

  task automatic start2();
    sdaDrv = 1'b1;
    tick(4);
    sdaDrv = 1'b0;
    tick(4);
    control_bit_clock = 1'b0;
    tick(2);
  endtask : start2

  task automatic stop2();
    sdaDrv = 1'b0;
    tick(2);
    control_bit_clock = 1'b1;
    tick(4);
    sdaDrv = 1'b1;
    tick(8);
  endtask : stop2

  // Address byte, then n bytes; nack gathers every missing ack
  task automatic i2cWr(input logic [7:0] a, input logic [23:0] d, input int n,
      output logic nack);
    logic [7:0] junk;
    logic r;
    start2();
    byte2(a, junk);
    bit2(1'b1, nack);
    for (int k = 0; k < n; k++) begin
      byte2(d[23-8*k -: 8], junk);
      bit2(1'b1, r);
      nack = nack | r;
    end
    stop2();
  endtask : i2cWr

  task automatic i2cRd(input logic [7:0] a, output logic [7:0] rx, output logic nack);
    logic [7:0] junk;
    logic r;
    start2();
    byte2(a, junk);
    bit2(1'b1, nack);
    byte2(8'hFF, rx);
    bit2(1'b1, r);
    stop2();
  endtask : i2cRd

  // Clock rests low outside frames; sample late in the high phase
  task automatic spi(input logic [23:0] tx, input int n, output logic [7:0] rx);
    control_bit_clock = 1'b0;
    tick(4);
    selStrap = 1'b0;
    tick(4);
    for (int i = n - 1; i >= 0; i--) begin
      dinStrap = tx[i];
      tick(4);
      control_bit_clock = 1'b1;
      tick(3);
      rx = {rx[6:0], sdaWire};
      tick(1);
      control_bit_clock = 1'b0;
    end
    tick(4);
    selStrap = 1'b1;
    tick(8);
  endtask : spi
endmodule : host_model

// [sim/test_dac_dual_mode_control_port.sv]
// Purpose: Self-checking bench for the dual-mode control port
// Assumes: host_model drives every host pin
// Notes: Two-wire scenarios first, since four-wire mode is sticky
`timescale 1ns/10ps
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin \
  badCount++; $display("Error at %0t: mismatch", $time); end end
module test_dac_dual_mode_control_port
  import dac_ctrl_pkg::*;
;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic control_bit_clock, selStrap, dinStrap, sdaDrv, sdaWire;
  logic dataLineOut, dataLineOe, fourWireMode, ack;
  logic [REG_COUNT*BYTE_W-1:0] settings;
  logic [7:0] rx;
  int badCount = 0;
  int samplesChecked = 0;

  always #25 ref_clk = ~ref_clk;

  // Shared wire with pull-up; either side may pull it low
  assign sdaWire = (dataLineOe ? dataLineOut : 1'b1) & sdaDrv;

  host_model host (.ref_clk(ref_clk), .sdaWire(sdaWire), .control_bit_clock(control_bit_clock), .selStrap(selStrap),
    .dinStrap(dinStrap), .sdaDrv(sdaDrv));
  dac_dual_mode_control_port uut (.ref_clk(ref_clk), .resetn(resetn), .controlBitClock(control_bit_clock),
    .addressStrapLow(selStrap), .controlSerialIn(dinStrap), .dataLineIn(sdaWire),
    .dataLineOut(dataLineOut), .dataLineOe(dataLineOe), .fourWireMode(fourWireMode),
    .settings(settings));

  task automatic summarize();
    if (badCount == 0 && samplesChecked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic t_i2c_write();
    `CHK(fourWireMode, 1'b0)
    host.i2cWr(8'h26, 24'h861122, 3, ack);
    `CHK(ack, 1'b0)
    `CHK(settings[8*6 +: 8], 8'h11)
    `CHK(settings[8*7 +: 8], 8'h22)
    host.i2cWr(8'h26, 24'h0355A6, 3, ack);
    `CHK(ack, 1'b0)
    `CHK(settings[8*3 +: 8], 8'hA6)
    `CHK(settings[8*4 +: 8], 8'h00)
  endtask : t_i2c_write

  // Wrong strap bits or wrong fixed bits get no ack and no write
  task automatic t_i2c_miss();
    logic [7:0] addrs [3] = '{8'h24, 8'h22, 8'h36};
    foreach (addrs[i]) begin
      host.i2cWr(addrs[i], 24'h03FF00, 2, ack);
      `CHK(ack, 1'b1)
      `CHK(settings[8*3 +: 8], 8'hA6)
    end
  endtask : t_i2c_miss

  task automatic t_i2c_read();
    host.i2cRd(8'h27, rx, ack);
    `CHK(ack, 1'b0)
    `CHK(rx, 8'hA6)
    `CHK(fourWireMode, 1'b0)
  endtask : t_i2c_read

  task automatic t_spi_write();
    host.spi({7'h10, 1'b0, 8'h02, 8'h5C}, 24, rx);
    `CHK(fourWireMode, 1'b1)
    `CHK(settings[8*2 +: 8], 8'h5C)
    host.spi({7'h10, 1'b0, 8'h04, 8'hC6}, 24, rx);
    `CHK(settings[8*4 +: 8], 8'hC6)
    `CHK(settings[8*2 +: 8], 8'h5C)
  endtask : t_spi_write

  // Foreign address, then a read frame carrying extra bits
  task automatic t_spi_miss();
    host.spi({7'h11, 1'b0, 8'h02, 8'hFF}, 24, rx);
    `CHK(settings[8*2 +: 8], 8'h5C)
    host.spi({7'h10, 1'b1, 8'h02, 8'hFF}, 24, rx);
    `CHK(settings[8*2 +: 8], 8'h5C)
  endtask : t_spi_miss

  task automatic t_spi_read();
    host.spi({8'h00, 7'h10, 1'b1, 8'h00}, 16, rx);
    `CHK(rx, 8'hC6)
  endtask : t_spi_read

  task automatic t_hold();
    host.tick(40);
    `CHK(fourWireMode, 1'b1)
    `CHK(settings[8*3 +: 8], 8'hA6)
  endtask : t_hold

  // Reset for 20 cycles, then the scenarios in mode order
  initial begin
    repeat (20) @(posedge ref_clk);
    #1 resetn = 1'b1;
    host.tick(4);
    t_i2c_write();
    t_i2c_miss();
    t_i2c_read();
    t_spi_write();
    t_spi_miss();
    t_spi_read();
    t_hold();
    summarize();
  end

  // Watchdog: nearly eight times the expected run length
  initial begin
    #1000000;
    badCount++;
    summarize();
  end
endmodule : test_dac_dual_mode_control_port
